// File: rtl/scrsc_params.svh
`ifndef SCRSC_PARAMS_SVH
`define SCRSC_PARAMS_SVH
// register word offsets (byte addresses)
`define SCRSC_A_RUNCFG 8'h00
`define SCRSC_A_REGCTL 8'h04
`define SCRSC_A_WLOAD 8'h08
`define SCRSC_A_WCTL 8'h0c
`define SCRSC_A_WCNT 8'h10
`define SCRSC_A_CAUSE 8'h14
`define SCRSC_A_PEN 8'h18
`define SCRSC_A_STAT 8'h1c
// reset values
`define SCRSC_RUNCFG_RST 16'h17ec
`define SCRSC_WLOAD_RST 32'hffffffff
`define SCRSC_CAUSE_RST 4'h8
`define SCRSC_CAUSE_EXT_ONLY 4'h1
// field positions
`define SCRSC_CAUSE_WDOG 1
`define SCRSC_CAUSE_LDO 2
`define SCRSC_REGCTL_EN 8
`define SCRSC_REGCTL_FLAG 9
`define SCRSC_WCTL_INT 0
`define SCRSC_WCTL_RES 1
// voltage steps: code 0 is 2.25 V, code 10 is 2.75 V, 50 mV apart
`define SCRSC_VOLT_MAX 4'ha
`define SCRSC_CRYSTAL_MIN 4'h4
`define SCRSC_CRYSTAL_MAX 4'hf
`define SCRSC_PLL_DIV_MIN 4'h3
// timing
`define SCRSC_PLL_READY_TICKS 13'h1200
`define SCRSC_MCLK_NS 10
`define SCRSC_RST_HOLD_NS 80
`define SCRSC_RST_HOLD_CYC (((`SCRSC_RST_HOLD_NS)+(`SCRSC_MCLK_NS)-1)/(`SCRSC_MCLK_NS))
`define SCRSC_INT4_LAST 2'h3
`endif

// File: rtl/scrsc_pkg.sv
`default_nettype none
package scrsc_pkg;
  // clock source choice
  typedef enum logic [1:0] {
    osc_main = 2'b00,
    osc_int = 2'b01,
    osc_int4 = 2'b10
  } scrsc_osc_t;
  // internal reset sequencer
  typedef enum logic [1:0] {
    rst_idle = 2'b00,
    rst_hold = 2'b01,
    rst_rel = 2'b10
  } scrsc_rst_t;
  // run-mode clock configuration word
  typedef struct packed {
    logic int_osc_dis;
    logic main_osc_dis;
    logic sleep_src;
    logic [3:0] crystal_select;
    logic [3:0] system_clock_divider;
    logic divider_use_enable;
    logic pll_pwrdn;
    logic bypass;
    logic [1:0] oscillator_select;
  } scrsc_run_cfg_t;
endpackage // scrsc_pkg
`default_nettype wire

// File: rtl/scrsc_tick_div.sv
`default_nettype none
module scrsc_tick_div (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // input ticks and divisor minus one
  input wire logic tick_i,
  input wire logic [4:0] div_m1_i,
  // divided tick
  output logic tick_o
);
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic out_ff;
  logic nxt_out;

  // divisor is sampled only at wrap, so a change never cuts a period short
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_out = 1'b0;
    if (tick_i)
    begin
      if (cnt_ff == 5'h00)
      begin
        nxt_out = 1'b1;
        nxt_cnt = div_m1_i;
      end
      else
      begin
        nxt_cnt = cnt_ff - 5'h01;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_ff <= 5'h00;
      out_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  assign tick_o = out_ff;
endmodule // scrsc_tick_div
`default_nettype wire

// File: rtl/scrsc_top.sv
// Function
// - watchdog can interrupt at first expiry and request reset at second.
// - first expiry reloads the 32-bit counter from the reload value.
// - reset only on second zero with flag uncleared and reset enabled.
// - unserviced second expiry asserts internal reset, then releases for boot fetch.
// - regulator-fault reset off after reset; when enabled, fault sets flag and resets.
// - voltage adjust field spans 2.25 V to 2.75 V in small steps.
// - oscillator select 0 main, 1 internal, 2 internal over four.
// - internal oscillator divided by four is an extra source.
// - bypass clear feeds divider from PLL, set feeds selected oscillator.
// - system divider divides by field value plus one.
// - with PLL, codes 0 to 2 reserved; 3 gives 50 MHz, 15 default.
// - bypassed, code 0 divides by two like code 1.
// - converter clock divided from system clock down to 16.67 MHz on the PLL path; off it, converter clock equals system clock.
// - peripherals clocked from system clock, one enable per block.
// - run clock config holds sources, enables, divisors and crystal choice.
// - crystal choice limited to the enumerated crystal field values.
// - reset causes sticky across resets; external reset clears the others.
// - after PLL change wait 0x1200 main oscillator ticks before PLL use.
// - divider-use clear and no PLL gives undivided source clock.
//
// Local design decisions: the strobed register port and the placing of the registers.
`include "scrsc_params.svh"
`default_nettype none
module scrsc_top #(
  parameter logic [12:0] PLL_READY_TICKS = `SCRSC_PLL_READY_TICKS
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // source clock ticks
  input wire logic main_osc_tick_i,
  input wire logic int_osc_tick_i,
  input wire logic pll_tick_i,
  // reset sources
  input wire logic ext_rst_i,
  input wire logic ldo_unreg_i,
  // derived clock enables
  output logic sysclk_en_o,
  output logic adc_clk_en_o,
  output logic [7:0] periph_clk_en_o,
  // oscillator, pll and regulator control
  output logic pll_pwrdn_o,
  output logic main_osc_dis_o,
  output logic int_osc_dis_o,
  output logic [3:0] crystal_select_o,
  output logic [3:0] regulator_voltage_adjust_o,
  // reset and watchdog
  output logic sys_rst_o,
  output logic boot_fetch_o,
  output logic wdog_irq_o
);
  scrsc_pkg::scrsc_run_cfg_t run_cfg_ff, nxt_run_cfg, wr_cfg;
  logic [3:0] volt_ff, nxt_volt;
  logic ldo_en_ff, nxt_ldo_en, ldo_flag_ff, nxt_ldo_flag;
  logic [31:0] wload_ff, nxt_wload, wcnt_ff, nxt_wcnt;
  logic [1:0] wctl_ff, nxt_wctl;
  logic wflag_ff, nxt_wflag;
  logic [7:0] pen_ff, nxt_pen, periph_ff, nxt_periph;
  logic [3:0] cause_ff, nxt_cause;
  logic [31:0] rdata_ff, nxt_rdata;
  scrsc_pkg::scrsc_rst_t state_ff, nxt_state;
  logic [3:0] hold_ff, nxt_hold;
  logic sys_rst_ff, nxt_sys_rst, boot_ff, nxt_boot;
  logic [1:0] int4_cnt_ff, nxt_int4_cnt;
  logic int4_tick_ff, nxt_int4_tick;
  logic [12:0] pll_cnt_ff, nxt_pll_cnt;
  logic sel_pll_ff, nxt_sel_pll, sys_en_ff;
  logic pll_relock, pll_ready, src_tick, div_in, sys_tick;
  logic wdog_trip, ldo_trip, rst_start, is_idle, wl_wr, exp_now;
  logic [4:0] sys_div, adc_div;

  // system divider minus one for the active path
  function automatic logic [4:0] sys_div_m1(input logic [3:0] code, input logic use_pll,
                                            input logic use_div);
    logic [3:0] d;
    d = code;
    if (use_pll)
    begin
      if (code < `SCRSC_PLL_DIV_MIN)
        d = `SCRSC_PLL_DIV_MIN;
    end
    else if (!use_div)
      d = 4'h0;
    else if (code == 4'h0)
      d = 4'h1;
    return {1'b0, d};
  endfunction

  // converter divider minus one: PLL path is 200 MHz over code plus one,
  // so the product of both divisors must reach 12
  function automatic logic [4:0] adc_div_m1(input logic [3:0] code, input logic use_pll);
    logic [4:0] k;
    k = 5'h00;
    if (use_pll)
    begin
      if (code <= 4'h4)
        k = 5'h02;
      else if (code <= 4'ha)
        k = 5'h01;
    end
    return k;
  endfunction

  assign is_idle = (state_ff == scrsc_pkg::rst_idle);
  assign ldo_trip = ldo_en_ff && ldo_unreg_i && is_idle;
  assign rst_start = is_idle && (wdog_trip || ldo_trip || ext_rst_i);
  assign wl_wr = wr_i && (addr_i == `SCRSC_A_WLOAD);
  assign exp_now = sys_tick && wctl_ff[`SCRSC_WCTL_INT] && (wcnt_ff == 32'h0) && !wl_wr;
  assign wr_cfg = scrsc_pkg::scrsc_run_cfg_t'(wdata_i[15:0]);

  // software registers, sticky flags and cause record
  always_comb
  begin
    nxt_run_cfg = run_cfg_ff;
    nxt_volt = volt_ff;
    nxt_ldo_en = ldo_en_ff;
    nxt_ldo_flag = ldo_flag_ff;
    nxt_wload = wload_ff;
    nxt_wctl = wctl_ff;
    nxt_pen = pen_ff;
    nxt_cause = cause_ff;
    if (wr_i)
    begin
      if (addr_i == `SCRSC_A_RUNCFG)
      begin
        nxt_run_cfg = wr_cfg;
        if (wr_cfg.crystal_select < `SCRSC_CRYSTAL_MIN)
          nxt_run_cfg.crystal_select = run_cfg_ff.crystal_select;
      end
      else if (addr_i == `SCRSC_A_REGCTL)
      begin
        // out-of-range codes clamp rather than wrap to a low voltage
        nxt_volt = (wdata_i[3:0] > `SCRSC_VOLT_MAX) ? `SCRSC_VOLT_MAX : wdata_i[3:0];
        nxt_ldo_en = wdata_i[`SCRSC_REGCTL_EN];
        if (wdata_i[`SCRSC_REGCTL_FLAG])
          nxt_ldo_flag = 1'b0;
      end
      else if (addr_i == `SCRSC_A_WLOAD)
        nxt_wload = wdata_i;
      else if (addr_i == `SCRSC_A_WCTL)
        nxt_wctl = wdata_i[1:0];
      else if (addr_i == `SCRSC_A_PEN)
        nxt_pen = wdata_i[7:0];
      else if (addr_i == `SCRSC_A_CAUSE)
        nxt_cause = cause_ff & ~wdata_i[3:0];
    end
    // internal reset returns clock config, regulator enable and watchdog control to defaults; regulator flag and causes survive
    if (rst_start)
    begin
      nxt_run_cfg = `SCRSC_RUNCFG_RST;
      nxt_ldo_en = 1'b0;
      nxt_wctl = 2'h0;
    end
    if (ldo_trip)
    begin
      nxt_ldo_flag = 1'b1;
      nxt_cause[`SCRSC_CAUSE_LDO] = 1'b1;
    end
    if (wdog_trip)
      nxt_cause[`SCRSC_CAUSE_WDOG] = 1'b1;
    if (ext_rst_i)
      nxt_cause = `SCRSC_CAUSE_EXT_ONLY;
    pll_relock = (nxt_run_cfg.crystal_select != run_cfg_ff.crystal_select) ||
                 (run_cfg_ff.pll_pwrdn && !nxt_run_cfg.pll_pwrdn);
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      run_cfg_ff <= `SCRSC_RUNCFG_RST;
      volt_ff <= 4'h0;
      ldo_en_ff <= 1'b0;
      ldo_flag_ff <= 1'b0;
      wload_ff <= `SCRSC_WLOAD_RST;
      wctl_ff <= 2'h0;
      pen_ff <= 8'h00;
      cause_ff <= `SCRSC_CAUSE_RST;
    end
    else
    begin
      run_cfg_ff <= nxt_run_cfg;
      volt_ff <= nxt_volt;
      ldo_en_ff <= nxt_ldo_en;
      ldo_flag_ff <= nxt_ldo_flag;
      wload_ff <= nxt_wload;
      wctl_ff <= nxt_wctl;
      pen_ff <= nxt_pen;
      cause_ff <= nxt_cause;
    end
  end

  // watchdog counts system clock ticks; clear is placed before the set
  always_comb
  begin
    nxt_wcnt = wcnt_ff;
    nxt_wflag = wflag_ff;
    wdog_trip = 1'b0;
    if (wr_i && (addr_i == `SCRSC_A_WCNT))
      nxt_wflag = 1'b0;
    if (wl_wr)
      nxt_wcnt = wdata_i;
    else if (sys_tick && wctl_ff[`SCRSC_WCTL_INT])
    begin
      if (wcnt_ff == 32'h0)
      begin
        if (!wflag_ff)
        begin
          nxt_wflag = 1'b1;
          nxt_wcnt = wload_ff;
        end
        else if (wctl_ff[`SCRSC_WCTL_RES])
          wdog_trip = is_idle;
        else
          nxt_wcnt = wload_ff;
      end
      else
        nxt_wcnt = wcnt_ff - 32'h1;
    end
    if (rst_start)
    begin
      nxt_wflag = 1'b0;
      nxt_wcnt = `SCRSC_WLOAD_RST;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wcnt_ff <= `SCRSC_WLOAD_RST;
      wflag_ff <= 1'b0;
    end
    else
    begin
      wcnt_ff <= nxt_wcnt;
      wflag_ff <= nxt_wflag;
    end
  end

  // internal reset sequencer: hold, then one boot-fetch cycle
  always_comb
  begin
    nxt_state = state_ff;
    nxt_hold = hold_ff;
    case (state_ff)
      scrsc_pkg::rst_idle:
        if (rst_start)
        begin
          nxt_state = scrsc_pkg::rst_hold;
          nxt_hold = 4'(`SCRSC_RST_HOLD_CYC - 1);
        end
      scrsc_pkg::rst_hold:
        if (hold_ff == 4'h0)
          nxt_state = scrsc_pkg::rst_rel;
        else
          nxt_hold = hold_ff - 4'h1;
      scrsc_pkg::rst_rel:
        nxt_state = scrsc_pkg::rst_idle;
      default:
        nxt_state = scrsc_pkg::rst_idle;
    endcase
    nxt_sys_rst = (nxt_state == scrsc_pkg::rst_hold);
    nxt_boot = (nxt_state == scrsc_pkg::rst_rel);
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= scrsc_pkg::rst_idle;
      hold_ff <= 4'h0;
      sys_rst_ff <= 1'b0;
      boot_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      hold_ff <= nxt_hold;
      sys_rst_ff <= nxt_sys_rst;
      boot_ff <= nxt_boot;
    end
  end

  // source selection, pll lock wait and path switch at divider wrap only
  always_comb
  begin
    nxt_int4_cnt = int4_cnt_ff;
    nxt_int4_tick = 1'b0;
    if (int_osc_tick_i && !run_cfg_ff.int_osc_dis)
    begin
      nxt_int4_cnt = int4_cnt_ff + 2'h1;
      nxt_int4_tick = (int4_cnt_ff == `SCRSC_INT4_LAST);
    end
    case (run_cfg_ff.oscillator_select)
      scrsc_pkg::osc_int: src_tick = int_osc_tick_i && !run_cfg_ff.int_osc_dis;
      scrsc_pkg::osc_int4: src_tick = int4_tick_ff;
      default: src_tick = main_osc_tick_i && !run_cfg_ff.main_osc_dis;
    endcase
    nxt_pll_cnt = pll_cnt_ff;
    if (pll_relock)
      nxt_pll_cnt = PLL_READY_TICKS;
    else if (main_osc_tick_i && (pll_cnt_ff != 13'h0))
      nxt_pll_cnt = pll_cnt_ff - 13'h1;
    pll_ready = (pll_cnt_ff == 13'h0) && !run_cfg_ff.pll_pwrdn;
    // the path changes only on a divider wrap to keep pulses whole
    nxt_sel_pll = sys_tick ? (!run_cfg_ff.bypass && pll_ready) : sel_pll_ff;
    div_in = sel_pll_ff ? pll_tick_i : src_tick;
    sys_div = sys_div_m1(run_cfg_ff.system_clock_divider, sel_pll_ff,
                         run_cfg_ff.divider_use_enable);
    adc_div = adc_div_m1(run_cfg_ff.system_clock_divider, sel_pll_ff);
    nxt_periph = {8{sys_tick}} & pen_ff;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      int4_cnt_ff <= 2'h0;
      int4_tick_ff <= 1'b0;
      pll_cnt_ff <= 13'h0;
      sel_pll_ff <= 1'b0;
      sys_en_ff <= 1'b0;
      periph_ff <= 8'h00;
    end
    else
    begin
      int4_cnt_ff <= nxt_int4_cnt;
      int4_tick_ff <= nxt_int4_tick;
      pll_cnt_ff <= nxt_pll_cnt;
      sel_pll_ff <= nxt_sel_pll;
      sys_en_ff <= sys_tick;
      periph_ff <= nxt_periph;
    end
  end

  // system clock divider
  scrsc_tick_div u_sys_div (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .tick_i(div_in),
    .div_m1_i(sys_div),
    .tick_o(sys_tick)
  );

  // converter clock divider fed by the system clock tick
  scrsc_tick_div u_adc_div (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .tick_i(sys_tick),
    .div_m1_i(adc_div),
    .tick_o(adc_clk_en_o)
  );

  // read data valid only in the cycle after the strobe
  always_comb
  begin
    nxt_rdata = 32'h0;
    if (rd_i)
    begin
      if (addr_i == `SCRSC_A_RUNCFG)
        nxt_rdata = {16'h0, run_cfg_ff};
      else if (addr_i == `SCRSC_A_REGCTL)
        nxt_rdata = {22'h0, ldo_flag_ff, ldo_en_ff, 4'h0, volt_ff};
      else if (addr_i == `SCRSC_A_WLOAD)
        nxt_rdata = wload_ff;
      else if (addr_i == `SCRSC_A_WCTL)
        nxt_rdata = {30'h0, wctl_ff};
      else if (addr_i == `SCRSC_A_WCNT)
        nxt_rdata = wcnt_ff;
      else if (addr_i == `SCRSC_A_CAUSE)
        nxt_rdata = {28'h0, cause_ff};
      else if (addr_i == `SCRSC_A_PEN)
        nxt_rdata = {24'h0, pen_ff};
      else if (addr_i == `SCRSC_A_STAT)
        nxt_rdata = {29'h0, sel_pll_ff, pll_ready, wflag_ff};
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_ff <= 32'h0;
    else
      rdata_ff <= nxt_rdata;
  end

  // outputs, all from flip-flops
  assign rdata_o = rdata_ff;
  assign sysclk_en_o = sys_en_ff;
  assign periph_clk_en_o = periph_ff;
  assign pll_pwrdn_o = run_cfg_ff.pll_pwrdn;
  assign main_osc_dis_o = run_cfg_ff.main_osc_dis;
  assign int_osc_dis_o = run_cfg_ff.int_osc_dis;
  assign crystal_select_o = run_cfg_ff.crystal_select;
  assign regulator_voltage_adjust_o = volt_ff;
  assign sys_rst_o = sys_rst_ff;
  assign boot_fetch_o = boot_ff;
  assign wdog_irq_o = wflag_ff;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_hold;
    sys_rst_ff [*8];
  endsequence
  sequence s_boot;
    !sys_rst_ff && boot_ff;
  endsequence

  a_wdog_first_flag: assert property (
    exp_now && !wflag_ff && !rst_start |=> wflag_ff)
    else $error("first watchdog expiry did not raise flag");
  a_wdog_reload_val: assert property (
    exp_now && !wflag_ff && !rst_start |=> wcnt_ff == $past(wload_ff))
    else $error("watchdog did not reload on first expiry");
  a_wdog_second_rst: assert property (
    exp_now && wflag_ff && wctl_ff[`SCRSC_WCTL_RES] && is_idle |=> sys_rst_ff)
    else $error("second watchdog expiry did not reset");
  a_rst_seq_boot: assert property (
    rst_start |=> s_hold ##1 s_boot)
    else $error("internal reset sequence malformed");
  // an external reset in the same cycle wipes the regulator cause bit, so it is left out
  a_ldo_fault_rst: assert property (
    ldo_trip && !ext_rst_i |=> ldo_flag_ff && sys_rst_ff && cause_ff[`SCRSC_CAUSE_LDO])
    else $error("regulator fault did not flag and reset");
  a_volt_in_range: assert property (
    volt_ff <= `SCRSC_VOLT_MAX)
    else $error("voltage adjust out of range");
  a_int4_tick_rate: assert property (
    int4_tick_ff |-> $past(int_osc_tick_i) && $past(int4_cnt_ff) == `SCRSC_INT4_LAST)
    else $error("internal quarter tick off rate");
  a_pll_div_floor: assert property (
    sel_pll_ff |-> sys_div >= 5'h03)
    else $error("reserved divider used on pll path");
  a_byp_div_two: assert property (
    !sel_pll_ff && run_cfg_ff.divider_use_enable && run_cfg_ff.system_clock_divider == 4'h0
    |-> sys_div == 5'h01)
    else $error("bypass code zero not divide by two");
  a_ext_cause_only: assert property (
    ext_rst_i |=> cause_ff == `SCRSC_CAUSE_EXT_ONLY)
    else $error("external reset did not clear other causes");
  a_pll_lock_wait: assert property (
    pll_relock |=> pll_cnt_ff == PLL_READY_TICKS && !pll_ready)
    else $error("pll lock wait not started");
  // the path may only move right after a divider wrap, never mid-period
  a_path_switch_wrap: assert property (
    $changed(sel_pll_ff) |-> $past(sys_tick))
    else $error("clock path changed away from a divider wrap");
endmodule // scrsc_top
`default_nettype wire

// File: tb/tb.sv
`include "scrsc_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // short pll relock count keeps the run brief
  localparam logic [12:0] READY_TICKS = 13'h10;
  logic mclk_i, rst_i, wr_i, rd_i, ext_rst_i, ldo_unreg_i;
  logic main_osc_tick_i, int_osc_tick_i, pll_tick_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o, v;
  logic sysclk_en_o, adc_clk_en_o, pll_pwrdn_o, main_osc_dis_o, int_osc_dis_o;
  logic sys_rst_o, boot_fetch_o, wdog_irq_o;
  logic [7:0] periph_clk_en_o;
  logic [3:0] crystal_select_o, regulator_voltage_adjust_o;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int n, hits;
  // bypass table: source, divider use, code, expected tick period
  scrsc_pkg::scrsc_osc_t t_osc [7] = '{scrsc_pkg::osc_main, scrsc_pkg::osc_int,
    scrsc_pkg::osc_int4, scrsc_pkg::osc_main, scrsc_pkg::osc_main, scrsc_pkg::osc_int,
    scrsc_pkg::osc_int4};
  logic t_use [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic [3:0] t_div [7] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h5, 4'h2};
  int t_per [7] = '{2, 1, 4, 4, 4, 6, 12};

  scrsc_top #(.PLL_READY_TICKS(READY_TICKS)) i_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .main_osc_tick_i(main_osc_tick_i),
    .int_osc_tick_i(int_osc_tick_i), .pll_tick_i(pll_tick_i), .ext_rst_i(ext_rst_i),
    .ldo_unreg_i(ldo_unreg_i), .sysclk_en_o(sysclk_en_o), .adc_clk_en_o(adc_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .pll_pwrdn_o(pll_pwrdn_o),
    .main_osc_dis_o(main_osc_dis_o), .int_osc_dis_o(int_osc_dis_o),
    .crystal_select_o(crystal_select_o),
    .regulator_voltage_adjust_o(regulator_voltage_adjust_o), .sys_rst_o(sys_rst_o),
    .boot_fetch_o(boot_fetch_o), .wdog_irq_o(wdog_irq_o)
  );

  // clock; main oscillator edges every other cycle so sources differ in rate
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    main_osc_tick_i <= ~main_osc_tick_i;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // register port: strobe for one cycle, read data stands in the next cycle only
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp, what);
  endtask

  function automatic logic [31:0] cfg(scrsc_pkg::scrsc_osc_t o, logic byp, logic pd,
                                      logic use_d, logic [3:0] dv);
    scrsc_pkg::scrsc_run_cfg_t c;
    c = '0;
    c.crystal_select = 4'hb;
    c.system_clock_divider = dv;
    c.divider_use_enable = use_d;
    c.pll_pwrdn = pd;
    c.bypass = byp;
    c.oscillator_select = o;
    return {16'h0000, c};
  endfunction

  // cycles between two enable pulses of the system or converter tick
  task automatic period(input logic adc, output int p);
    int k;
    k = 0;
    p = 0;
    while ((adc ? adc_clk_en_o : sysclk_en_o) !== 1'b1 && k < 100)
    begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    do
    begin
      @(posedge mclk_i);
      #1;
      p++;
    end while ((adc ? adc_clk_en_o : sysclk_en_o) !== 1'b1 && p < 100);
  endtask
  task automatic per_chk(input logic adc, input int exp, input string what);
    int p;
    period(adc, p);
    period(adc, p);
    chk(p, exp, what);
  endtask

  task automatic wait_sig(input logic sel, input int lim);
    n = 0;
    while ((sel ? sys_rst_o : wdog_irq_o) !== 1'b1 && n < lim)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(32'(n < lim), 32'h1, "rise in time");
  endtask

  // internal reset: 8 cycles high, then a one-cycle fetch pulse
  task automatic int_reset;
    int h;
    wait_sig(1'b1, 40);
    h = 0;
    // sources drop on an edge inside the hold, where new triggers are ignored
    while (sys_rst_o === 1'b1 && h < 20)
    begin
      @(posedge mclk_i);
      ldo_unreg_i <= 1'b0;
      ext_rst_i <= 1'b0;
      #1;
      h++;
    end
    chk(h, 8, "internal reset length");
    chk({31'h0, boot_fetch_o}, 32'h1, "fetch start");
    @(posedge mclk_i);
    #1;
    chk({31'h0, boot_fetch_o}, 32'h0, "fetch pulse end");
  endtask

  // cycles with internal reset high over a window
  task automatic quiet(input int len);
    hits = 0;
    repeat (len)
    begin
      @(posedge mclk_i);
      #1;
      hits += int'(sys_rst_o === 1'b1);
    end
  endtask

  initial
  begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    ext_rst_i = 1'b0;
    ldo_unreg_i = 1'b0;
    main_osc_tick_i = 1'b0;
    int_osc_tick_i = 1'b1;
    pll_tick_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    chk({28'h0, crystal_select_o}, 32'hb, "crystal at reset");
    chk({29'h0, pll_pwrdn_o, main_osc_dis_o, int_osc_dis_o}, 32'h4, "osc ctl");
    rdchk(8'h00, 32'h17ec, "run cfg reset");
    rdchk(8'h04, 32'h0, "regulator reset");
    rdchk(8'h08, 32'hffffffff, "reload reset");
    rdchk(8'h14, 32'h8, "cause at power-on");
    rdchk(8'h20, 32'h0, "unmapped read");
    wr(8'h04, 32'h4);
    chk({28'h0, regulator_voltage_adjust_o}, 32'h4, "voltage code");
    wr(8'h04, 32'hf);
    chk({28'h0, regulator_voltage_adjust_o}, 32'ha, "voltage top");
    wr(8'h00, 32'h05ec);
    chk({28'h0, crystal_select_o}, 32'hb, "crystal code refused");
    wr(8'h00, 32'h0dec);
    chk({28'h0, crystal_select_o}, 32'h6, "crystal code taken");
    // bypass paths over every source and boundary codes
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h00, cfg(t_osc[i], 1'b1, 1'b1, t_use[i], t_div[i]));
      rdchk(8'h00, cfg(t_osc[i], 1'b1, 1'b1, t_use[i], t_div[i]), "cfg readback");
      per_chk(1'b0, t_per[i], "bypass period");
      per_chk(1'b1, t_per[i], "bypass converter");
    end
    // pll path waits for relock before taking over
    wr(8'h00, cfg(scrsc_pkg::osc_main, 1'b0, 1'b0, 1'b1, 4'h3));
    rdchk(8'h1c, 32'h0, "pll not ready");
    repeat (60) @(posedge mclk_i);
    rdchk(8'h1c, 32'h6, "pll ready in use");
    per_chk(1'b0, 4, "pll code 3");
    per_chk(1'b1, 12, "converter at code 3");
    wr(8'h00, cfg(scrsc_pkg::osc_main, 1'b0, 1'b0, 1'b1, 4'h1));
    per_chk(1'b0, 4, "pll reserved code");
    wr(8'h00, cfg(scrsc_pkg::osc_main, 1'b0, 1'b0, 1'b1, 4'hb));
    per_chk(1'b0, 12, "pll code b");
    per_chk(1'b1, 12, "converter at code b");
    wr(8'h18, 32'ha5);
    per_chk(1'b0, 12, "period with enables");
    chk({24'h0, periph_clk_en_o}, 32'ha5, "peripheral enables");
    // watchdog: first expiry flags, second resets only when enabled
    wr(8'h00, cfg(scrsc_pkg::osc_int, 1'b1, 1'b1, 1'b0, 4'h0));
    wr(8'h08, 32'ha);
    wr(8'h0c, 32'h1);
    wait_sig(1'b0, 40);
    rd(8'h10, v);
    chk(32'(v <= 32'ha && v >= 32'h5), 32'h1, "counter reloaded");
    quiet(40);
    chk(hits, 0, "no reset without enable");
    chk({31'h0, wdog_irq_o}, 32'h1, "flag held");
    wr(8'h10, 32'h0);
    chk({31'h0, wdog_irq_o}, 32'h0, "flag cleared");
    wr(8'h0c, 32'h3);
    wait_sig(1'b0, 40);
    int_reset();
    rdchk(8'h14, 32'ha, "cause watchdog");
    chk({31'h0, wdog_irq_o}, 32'h0, "flag after reset");
    rdchk(8'h00, 32'h17ec, "cfg restored");
    // regulator fault only resets when enabled
    @(posedge mclk_i);
    ldo_unreg_i <= 1'b1;
    quiet(10);
    chk(hits, 0, "fault reset off");
    wr(8'h04, 32'h100);
    int_reset();
    rdchk(8'h04, 32'h200, "fault flag");
    rdchk(8'h14, 32'he, "cause regulator");
    wr(8'h04, 32'h200);
    rdchk(8'h04, 32'h0, "fault flag clear");
    // external reset wipes the other causes
    @(posedge mclk_i);
    ext_rst_i <= 1'b1;
    int_reset();
    rdchk(8'h14, 32'h1, "cause external");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
